/* File: src/exception_priority_vector.sv */
`timescale 1ns/1ps
`default_nettype none
//
// Behaviour
// RULE1 - simultaneous exceptions are taken one at a time: reset, then trace, then interrupt, then trap.
// RULE2 - reset handling starts right after a rising edge on either reset pin or on watchdog overflow.
// RULE3 - the CPU is held in reset while the power-on pin is low and in manual reset while the manual pin is low.
// RULE4 - a trace exception is taken at the end of an instruction or handling when the trace enable bit is one.
// RULE5 - trace is generated only in interrupt control mode 2.
// RULE6 - no trace follows the return-from-exception instruction.
// RULE7 - an interrupt starts at the end of an instruction or handling while a request is presented.
// RULE8 - interrupts are not detected right after a control modify instruction or after reset handling.
// RULE9 - a trap instruction always starts trap handling in program execution state.
// RULE10 - each source uses its own vector number (0,1,5,6,7,8-11,16-23,24-127).
// RULE11 - each vector takes four bytes at four times its number, low sixteen bits up to 01FC.
// RULE12 - only the advanced four-byte vector layout exists.
// RULE13 - the manual reset pin counts only once the manual reset enable bit is one.
// RULE14 - an accepted exception yields the vector address of the highest pending source to the sequencer.
module exception_priority_vector (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        powerOnResetPinN,
  input  wire logic        manualResetPinN,
  input  wire logic        manualResetEnableBit,
  input  wire logic        watchdogOverflow,
  input  wire logic        watchdogManual,
  input  wire logic        traceEnableBit,
  input  wire logic [1:0]  intCtrlMode,
  input  wire logic        instrDone,
  input  wire logic        instrWasRte,
  input  wire logic        instrWasCtrlMod,
  input  wire logic        intReq,
  input  wire logic [6:0]  intReqVec,
  input  wire logic        trapExec,
  input  wire logic [1:0]  trapNum,
  input  wire logic        seqReady,
  output logic             cpuResetHold,
  output logic             cpuManualHold,
  output logic             excStart,
  output logic [3:0]       excKind,
  output logic [6:0]       excVecNum,
  output logic [15:0]      excVecAddr
);
  epv_req_if req ();

  typedef enum logic [2:0] {
    EPV_IDLE   = 3'b001,
    EPV_ISSUE  = 3'b010,
    EPV_RSTRUN = 3'b100
  } epv_state_type;

  epv_state_type state_q, state_d;
  logic          holdPor_q, holdPor_d;
  logic          holdMan_q, holdMan_d;
  logic          start_q, start_d;
  logic [3:0]    kind_q, kind_d;
  logic [6:0]    vec_q, vec_d;
  logic [15:0]   addr_q, addr_d;
  logic          resetAck;
  logic          resetDone;
  logic          tracePend_q, tracePend_d;
  logic          intrPend_q, intrPend_d;
  logic [6:0]    intrVec_q, intrVec_d;
  logic          trapPend_q, trapPend_d;
  logic [6:0]    trapVec_q, trapVec_d;
  logic          noHold;

  epv_sources u_sources (
    .mclk                 (mclk),
    .reset                (reset),
    .powerOnResetPinN     (powerOnResetPinN),
    .manualResetPinN      (manualResetPinN),
    .manualResetEnableBit (manualResetEnableBit),
    .watchdogOverflow     (watchdogOverflow),
    .watchdogManual       (watchdogManual),
    .traceEnableBit       (traceEnableBit),
    .intCtrlMode          (intCtrlMode),
    .instrDone            (instrDone),
    .instrWasRte          (instrWasRte),
    .instrWasCtrlMod      (instrWasCtrlMod),
    .resetHandlingDone    (resetDone),
    .intReq               (intReq),
    .intReqVec            (intReqVec),
    .trapExec             (trapExec),
    .trapNum              (trapNum),
    .resetAck             (resetAck),
    .req                  (req)
  );

  // reset request is consumed when the sequencer takes it
  assign resetAck  = (state_q == EPV_ISSUE) && seqReady && (kind_q == 4'(epv_pkg::EPV_KIND_RESET));
  // reset handling is over once the sequencer takes the reset vector
  assign resetDone = resetAck;

  // pending events wait here until issued; a new event beats the issue clear in the same cycle
  always_comb begin
    tracePend_d = tracePend_q;
    intrPend_d  = intrPend_q;
    intrVec_d   = intrVec_q;
    trapPend_d  = trapPend_q;
    trapVec_d   = trapVec_q;
    if (state_q == EPV_IDLE && start_d) begin
      case (kind_d)
        4'(epv_pkg::EPV_KIND_TRACE): tracePend_d = 1'b0;
        4'(epv_pkg::EPV_KIND_INTR):  intrPend_d  = 1'b0;
        4'(epv_pkg::EPV_KIND_TRAP):  trapPend_d  = 1'b0;
        default: ;
      endcase
    end
    if (req.tracePend) begin
      tracePend_d = 1'b1;
    end
    if (req.intrPend) begin
      intrPend_d = 1'b1;
      intrVec_d  = req.intrVec;
    end
    if (req.trapPend) begin // RULE9
      trapPend_d = 1'b1;
      trapVec_d  = req.trapVec;
    end
    // a reset hold on either pin drops lower exceptions in flight
    if (holdPor_d || holdMan_d) begin
      tracePend_d = 1'b0;
      intrPend_d  = 1'b0;
      trapPend_d  = 1'b0;
    end
  end

  // fixed-priority pick and one-at-a-time issue to the sequencer
  always_comb begin
    state_d   = state_q;
    start_d   = 1'b0;
    kind_d    = kind_q;
    vec_d     = vec_q;
    addr_d    = addr_q;
    holdPor_d = ~powerOnResetPinN; // RULE3
    holdMan_d = ~manualResetPinN & manualResetEnableBit & powerOnResetPinN; // RULE3 RULE13
    case (state_q)
      EPV_IDLE: begin
        if (holdPor_d || holdMan_d) begin
          state_d = EPV_IDLE;
        end else if (req.resetPend) begin // RULE1
          start_d = 1'b1;
          kind_d  = 4'(epv_pkg::EPV_KIND_RESET);
          vec_d   = req.resetVec;
        end else if (tracePend_q) begin // RULE1
          start_d = 1'b1;
          kind_d  = 4'(epv_pkg::EPV_KIND_TRACE);
          vec_d   = epv_pkg::VEC_TRACE;
        end else if (intrPend_q) begin // RULE1
          start_d = 1'b1;
          kind_d  = 4'(epv_pkg::EPV_KIND_INTR);
          vec_d   = intrVec_q;
        end else if (trapPend_q) begin // RULE1
          start_d = 1'b1;
          kind_d  = 4'(epv_pkg::EPV_KIND_TRAP);
          vec_d   = trapVec_q;
        end
        if (start_d) begin
          state_d = EPV_ISSUE;
          addr_d  = epv_pkg::epv_vec_addr(vec_d); // RULE11 RULE12 RULE14
        end
      end
      EPV_ISSUE: begin
        // hold the vector until the sequencer takes it
        start_d = ~seqReady;
        if (holdPor_d || holdMan_d) begin
          state_d = EPV_IDLE;
          start_d = 1'b0;
        end else if (seqReady) begin
          state_d = EPV_RSTRUN;
        end
      end
      EPV_RSTRUN: begin
        // one cycle gap so one exception is started at a time
        state_d = EPV_IDLE;
      end
      default: state_d = EPV_IDLE;
    endcase
  end

  // arbiter flops; every output comes straight from one of these
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q     <= EPV_IDLE;
      holdPor_q   <= 1'b1;
      holdMan_q   <= 1'b0;
      start_q     <= 1'b0;
      kind_q      <= 4'h0;
      vec_q       <= 7'h00;
      addr_q      <= 16'h0000;
    end else begin
      state_q     <= state_d;
      holdPor_q   <= holdPor_d;
      holdMan_q   <= holdMan_d;
      start_q     <= start_d;
      kind_q      <= kind_d;
      vec_q       <= vec_d;
      addr_q      <= addr_d;
    end
  end

  // pending-flag flops, a group of their own
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tracePend_q <= 1'b0;
      intrPend_q  <= 1'b0;
      intrVec_q   <= 7'h00;
      trapPend_q  <= 1'b0;
      trapVec_q   <= 7'h00;
    end else begin
      tracePend_q <= tracePend_d;
      intrPend_q  <= intrPend_d;
      intrVec_q   <= intrVec_d;
      trapPend_q  <= trapPend_d;
      trapVec_q   <= trapVec_d;
    end
  end

  assign cpuResetHold  = holdPor_q;
  assign cpuManualHold = holdMan_q;
  assign excStart      = start_q;
  assign excKind       = kind_q;
  assign excVecNum     = vec_q;
  assign excVecAddr    = addr_q;

  // checks
  addr_matches_vec_a: assert property (@(posedge mclk) disable iff (reset) // RULE11
    excStart |-> (excVecAddr == {7'h00, excVecNum, 2'h0}) && (excVecAddr <= epv_pkg::VEC_ADDR_LAST))
    else $error("vector address does not match vector number");
  por_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE3
    !powerOnResetPinN |=> cpuResetHold && !excStart)
    else $error("power-on reset not held");
  man_ignored_a: assert property (@(posedge mclk) disable iff (reset) // RULE13
    !manualResetEnableBit |=> !cpuManualHold)
    else $error("manual reset taken while disabled");
  reset_issue_a: assert property (@(posedge mclk) disable iff (reset) // RULE2
    ($rose(powerOnResetPinN) && state_q == EPV_IDLE && !cpuManualHold) |-> ##2 (excStart && excVecNum == 7'h00))
    else $error("power-on reset vector not issued");
  trace_vec_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
    (excStart && excKind == 4'h2) |-> excVecNum == 7'h05)
    else $error("trace vector wrong");
  trap_vec_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
    (excStart && excKind == 4'h8) |-> (excVecNum >= 7'h08 && excVecNum <= 7'h0B))
    else $error("trap vector out of range");
  trace_mode_a: assert property (@(posedge mclk) disable iff (reset) // RULE5
    (intCtrlMode != 2'h2 && req.tracePend) |-> 1'b0)
    else $error("trace raised outside mode 2");
  no_rte_trace_a: assert property (@(posedge mclk) disable iff (reset) // RULE6
    (instrDone && instrWasRte) |-> !req.tracePend)
    else $error("trace after return from exception");
  intr_blank_a: assert property (@(posedge mclk) disable iff (reset) // RULE8
    (instrDone && instrWasCtrlMod) |-> !req.intrPend)
    else $error("interrupt detected after control modify");
  prio_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
    (state_q == EPV_IDLE && tracePend_q && intrPend_q && !req.resetPend && !cpuResetHold
     && powerOnResetPinN && !(manualResetEnableBit && !manualResetPinN)) |=> excKind == 4'h2)
    else $error("trace not ahead of interrupt");

  // pins seen free of any reset hold; gates five of the checks below
  assign noHold = powerOnResetPinN && !(manualResetEnableBit && !manualResetPinN);

  // holds and the fixed order of issue
  man_hold_a: assert property (@(posedge mclk) disable iff (reset) // RULE3
    (manualResetEnableBit && !manualResetPinN && powerOnResetPinN) |=> cpuManualHold)
    else $error("manual reset not held");
  hold_quiet_a: assert property (@(posedge mclk) disable iff (reset) // RULE3
    (cpuResetHold || cpuManualHold) |-> !excStart)
    else $error("vector presented during reset hold");
  reset_first_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
    (state_q == EPV_IDLE && req.resetPend && noHold) |=> excKind == 4'h1)
    else $error("reset not ahead of other exceptions");
  start_gap_a: assert property (@(posedge mclk) disable iff (reset) // RULE1
    ($fell(excStart) && !cpuResetHold && !cpuManualHold) |=> !excStart)
    else $error("next exception started without a gap");

  // each accepted event must reach its pending flag
  trace_taken_a: assert property (@(posedge mclk) disable iff (reset) // RULE4
    (instrDone && traceEnableBit && intCtrlMode == 2'h2 && !instrWasRte && noHold) |=> tracePend_q)
    else $error("trace event lost");
  intr_taken_a: assert property (@(posedge mclk) disable iff (reset) // RULE7
    (instrDone && intReq && !instrWasCtrlMod && !resetDone && noHold) |=> intrPend_q)
    else $error("interrupt request lost");
  trap_taken_a: assert property (@(posedge mclk) disable iff (reset) // RULE9
    (trapExec && noHold) |=> trapPend_q)
    else $error("trap instruction lost");

  // presentation to the sequencer
  reset_vec_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
    (excStart && excKind == 4'h1) |-> excVecNum <= 7'h01)
    else $error("reset vector out of range");
  intr_vec_a: assert property (@(posedge mclk) disable iff (reset) // RULE10
    (excStart && excKind == 4'h4) |-> (excVecNum == 7'h07 || excVecNum >= 7'h10))
    else $error("interrupt vector out of range");
  kind_onehot_a: assert property (@(posedge mclk) disable iff (reset) // RULE14
    excStart |-> $onehot(excKind))
    else $error("presented kind not one-hot");
  vec_held_a: assert property (@(posedge mclk) disable iff (reset) // RULE14
    (excStart && !seqReady && noHold) |=> (excStart && $stable(excVecAddr) && $stable(excKind)))
    else $error("vector changed before it was taken");
  ready_drop_a: assert property (@(posedge mclk) disable iff (reset) // RULE14
    (excStart && seqReady) |=> !excStart)
    else $error("vector still presented after it was taken");
endmodule // exception_priority_vector
`default_nettype wire

/* File: src/epv_pkg.sv */
package epv_pkg;
  // vector numbers of each source
  localparam logic [6:0] VEC_POWER_ON   = 7'h00;
  localparam logic [6:0] VEC_MANUAL     = 7'h01;
  localparam logic [6:0] VEC_TRACE      = 7'h05;
  localparam logic [6:0] VEC_DIRECT     = 7'h06;
  localparam logic [6:0] VEC_NMI        = 7'h07;
  localparam logic [6:0] VEC_TRAP_BASE  = 7'h08;
  localparam logic [6:0] VEC_EXT_BASE   = 7'h10;
  localparam logic [6:0] VEC_INT_FIRST  = 7'h18;
  localparam logic [6:0] VEC_LAST       = 7'h7F;
  // advanced-mode slot: four bytes per vector, low sixteen address bits
  localparam int         VEC_SHIFT      = 2;
  localparam logic [15:0] VEC_ADDR_LAST = 16'h01FC;
  // interrupt control mode in which trace works
  localparam logic [1:0] ICM_TRACE      = 2'h2;
  localparam logic [1:0] ICM_RESET      = 2'h0;

  typedef enum logic [3:0] {
    EPV_KIND_NONE  = 4'h0,
    EPV_KIND_RESET = 4'h1,
    EPV_KIND_TRACE = 4'h2,
    EPV_KIND_INTR  = 4'h4,
    EPV_KIND_TRAP  = 4'h8
  } epv_kind_type;

  // vector number to advanced-mode byte address
  function automatic logic [15:0] epv_vec_addr(input logic [6:0] vec);
    epv_vec_addr = {7'h00, vec, 2'h0};
  endfunction
endpackage

/* File: src/epv_req_if.sv */
`timescale 1ns/1ps
`default_nettype none
// pending-request summary passed from the source collector to the arbiter
interface epv_req_if;
  logic       resetPend;
  logic [6:0] resetVec;
  logic       tracePend;
  logic       intrPend;
  logic [6:0] intrVec;
  logic       trapPend;
  logic [6:0] trapVec;
  modport source (output resetPend, resetVec, tracePend, intrPend, intrVec, trapPend, trapVec);
  modport arbiter (input resetPend, resetVec, tracePend, intrPend, intrVec, trapPend, trapVec);
endinterface
`default_nettype wire

/* File: src/epv_sources.sv */
`timescale 1ns/1ps
`default_nettype none
// collects and qualifies the four exception sources
module epv_sources (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       powerOnResetPinN,
  input  wire logic       manualResetPinN,
  input  wire logic       manualResetEnableBit,
  input  wire logic       watchdogOverflow,
  input  wire logic       watchdogManual,
  input  wire logic       traceEnableBit,
  input  wire logic [1:0] intCtrlMode,
  input  wire logic       instrDone,
  input  wire logic       instrWasRte,
  input  wire logic       instrWasCtrlMod,
  input  wire logic       resetHandlingDone,
  input  wire logic       intReq,
  input  wire logic [6:0] intReqVec,
  input  wire logic       trapExec,
  input  wire logic [1:0] trapNum,
  input  wire logic       resetAck,
  epv_req_if.source       req
);
  logic porPrev_q, porPrev_d;
  logic mrsPrev_q, mrsPrev_d;
  logic resetPend_q, resetPend_d;
  logic [6:0] resetVec_q, resetVec_d;
  logic mrsPin;

  // pin ignored unless software enabled it
  assign mrsPin = manualResetPinN | ~manualResetEnableBit;

  // rising edge of a reset pin or a watchdog overflow raises the reset request
  always_comb begin
    porPrev_d   = powerOnResetPinN;
    mrsPrev_d   = mrsPin;
    resetPend_d = resetPend_q;
    resetVec_d  = resetVec_q;
    if (resetAck) begin
      resetPend_d = 1'b0;
    end
    if (!porPrev_q && powerOnResetPinN) begin // RULE2
      resetPend_d = 1'b1;
      resetVec_d  = epv_pkg::VEC_POWER_ON;
    end else if (!mrsPrev_q && mrsPin) begin // RULE2
      resetPend_d = 1'b1;
      resetVec_d  = epv_pkg::VEC_MANUAL;
    end else if (watchdogOverflow) begin // RULE2
      resetPend_d = 1'b1;
      resetVec_d  = watchdogManual ? epv_pkg::VEC_MANUAL : epv_pkg::VEC_POWER_ON;
    end
  end

  // power-on pin starts as if held low so its first release counts as a reset; manual pin starts released
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      porPrev_q   <= 1'b0;
      mrsPrev_q   <= 1'b1;
      resetPend_q <= 1'b0;
      resetVec_q  <= 7'h00;
    end else begin
      porPrev_q   <= porPrev_d;
      mrsPrev_q   <= mrsPrev_d;
      resetPend_q <= resetPend_d;
      resetVec_q  <= resetVec_d;
    end
  end

  assign req.resetPend = resetPend_q;
  assign req.resetVec  = resetVec_q;
  // trace only in mode 2 and never after a return from exception
  assign req.tracePend = (instrDone | resetHandlingDone) & traceEnableBit & // RULE4
                         (intCtrlMode == epv_pkg::ICM_TRACE) & ~instrWasRte; // RULE5 RULE6
  // interrupt detection blanked after control modify or reset handling
  assign req.intrPend  = instrDone & intReq & ~instrWasCtrlMod & ~resetHandlingDone; // RULE7 RULE8
  assign req.intrVec   = intReqVec;
  assign req.trapPend  = trapExec; // RULE9
  assign req.trapVec   = epv_pkg::VEC_TRAP_BASE + {5'h00, trapNum}; // RULE10
endmodule // epv_sources
`default_nettype wire

/* File: bench/epv_partner_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: reset pins, watchdog and interrupt controller, steered by bench commands
module epv_partner_model (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       porLow,
  input  wire logic       manLow,
  input  wire logic       manualResetEnableBit,
  input  wire logic       wdKick,
  input  wire logic       irqOn,
  input  wire logic [6:0] irqVec,
  input  wire logic       excStart,
  input  wire logic [3:0] excKind,
  input  wire logic       seqReady,
  output var logic        powerOnResetPinN = 1'b1,
  output var logic        manualResetPinN  = 1'b1,
  output var logic        watchdogOverflow = 1'b0,
  output logic            intReq,
  output var logic [6:0]  intReqVec = 7'h00
);
  logic acked;
  logic ackNow;
  assign ackNow = intReq && excStart && seqReady && (excKind == 4'h4);
  // pins are external, so they ignore the core reset and start released
  always @(posedge mclk) begin
    powerOnResetPinN <= !porLow;
    manualResetPinN  <= !(manLow && manualResetEnableBit);
    watchdogOverflow <= wdKick;
  end
  // request stands until the sequencer takes its vector; a dead vector line toggles
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      intReq <= 1'b0;
      acked  <= 1'b0;
    end else begin
      acked     <= irqOn && (acked || ackNow);
      intReq    <= irqOn && !acked && !ackNow;
      intReqVec <= (irqOn && !acked && !ackNow) ? irqVec : ~intReqVec;
    end
  end
endmodule // epv_partner_model
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0, reset = 1'b1, manEn = 1'b0, wdMan = 1'b0, traceEn = 1'b0;
  logic [1:0] icm = 2'h0, trapNum = 2'h0;
  logic done = 1'b0, wasRte = 1'b0, wasCm = 1'b0, trapExec = 1'b0, seqReady = 1'b0;
  logic porLow = 1'b0, manLow = 1'b0, wdKick = 1'b0, irqOn = 1'b0;
  logic [6:0] irqVec = 7'h07;
  wire logic porN, manN, wdOvf, intReq, resHold, manHold, excStart;
  wire logic [6:0] intReqVec, excVecNum;
  wire logic [3:0] excKind;
  wire logic [15:0] excVecAddr;
  logic [31:0] rs = 32'hE18975EB, ms = 32'hE18975EB;
  logic [10:0] expQ[$];
  logic [10:0] e;
  int mismatches = 0, cmp_count = 0;

  initial forever #2 mclk = ~mclk;

  exception_priority_vector exception_priority_vector_i (.mclk(mclk), .reset(reset), .powerOnResetPinN(porN),
    .manualResetPinN(manN), .manualResetEnableBit(manEn), .watchdogOverflow(wdOvf), .watchdogManual(wdMan),
    .traceEnableBit(traceEn), .intCtrlMode(icm), .instrDone(done), .instrWasRte(wasRte), .instrWasCtrlMod(wasCm),
    .intReq(intReq), .intReqVec(intReqVec), .trapExec(trapExec), .trapNum(trapNum), .seqReady(seqReady),
    .cpuResetHold(resHold), .cpuManualHold(manHold), .excStart(excStart), .excKind(excKind),
    .excVecNum(excVecNum), .excVecAddr(excVecAddr));
  epv_partner_model epv_partner_model_i (.mclk(mclk), .reset(reset), .porLow(porLow), .manLow(manLow),
    .manualResetEnableBit(manEn), .wdKick(wdKick), .irqOn(irqOn), .irqVec(irqVec), .excStart(excStart),
    .excKind(excKind), .seqReady(seqReady), .powerOnResetPinN(porN), .manualResetPinN(manN),
    .watchdogOverflow(wdOvf), .intReq(intReq), .intReqVec(intReqVec));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // sequencer stalls about a quarter of the time to stretch presentations
  always @(posedge mclk) begin
    rs = xs(rs);
    seqReady <= (rs[1:0] != 2'h0);
  end

  // a result is an accepted presentation; it must match the oldest note
  always @(posedge mclk) begin
    if (!reset && excStart === 1'b1 && seqReady === 1'b1) begin
      if (expQ.size() == 0) check("unexpected exception", 16'h0000, {12'h000, excKind});
      else begin
        e = expQ.pop_front();
        check("excKind", {12'h000, e[10:7]}, {12'h000, excKind});
        check("excVecNum", {9'h000, e[6:0]}, {9'h000, excVecNum});
        check("excVecAddr", {7'h00, e[6:0], 2'h0}, excVecAddr);
      end
    end
  end

  // waits for the notes to be used up and the presentation to drop
  task automatic drain();
    int i;
    tick(6);
    for (i = 0; i < 300 && (expQ.size() != 0 || excStart !== 1'b0); i++) tick(1);
    if (i == 300) begin
      check("drain timeout", 16'h0000, 16'h0001);
      close_out();
    end
  endtask

  task automatic pulseDone(input logic return_from_exception_instr, input logic cm);
    @(posedge mclk);
    done <= 1'b1;
    wasRte <= return_from_exception_instr;
    wasCm <= cm;
    @(posedge mclk);
    done <= 1'b0;
    wasRte <= 1'b0;
    wasCm <= 1'b0;
  endtask

  // main sequence
  initial begin
    expQ.push_back({4'h1, 7'h00});
    tick(3);
    reset <= 1'b0;
    drain();
    // power-on and manual pins held low, then released
    porLow <= 1'b1;
    tick(25);
    check("cpuResetHold", 16'h0001, {15'h0, resHold});
    expQ.push_back({4'h1, 7'h00});
    porLow <= 1'b0;
    drain();
    manEn <= 1'b1;
    manLow <= 1'b1;
    tick(25);
    check("cpuManualHold", 16'h0001, {15'h0, manHold});
    expQ.push_back({4'h1, 7'h01});
    manLow <= 1'b0;
    drain();
    for (int w = 0; w < 2; w++) begin
      wdMan <= w[0];
      expQ.push_back({4'h1, 6'h00, w[0]});
      wdKick <= 1'b1;
      tick(1);
      wdKick <= 1'b0;
      drain();
    end
    // every trap number
    for (int n = 0; n < 4; n++) begin
      expQ.push_back({4'h8, 5'h02, n[1:0]});
      trapExec <= 1'b1;
      trapNum <= n[1:0];
      tick(1);
      trapExec <= 1'b0;
      drain();
    end
    // trace only in mode 2, and never after return-from-exception
    traceEn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      icm <= m[1:0];
      if (m == 2) expQ.push_back({4'h2, 7'h05});
      pulseDone(1'b0, 1'b0);
      drain();
    end
    icm <= 2'h2;
    pulseDone(1'b1, 1'b0);
    drain();
    traceEn <= 1'b0;
    // interrupts: NMI and a random vector, none after a control modify
    for (int k = 0; k < 3; k++) begin
      ms = xs(ms);
      irqVec <= (k == 0) ? 7'h07 : 7'h10 + 7'(ms % 32'h70);
      irqOn <= 1'b1;
      tick(3);
      if (k == 2) pulseDone(1'b0, 1'b1);
      else begin
        expQ.push_back({4'h4, irqVec});
        pulseDone(1'b0, 1'b0);
      end
      drain();
      irqOn <= 1'b0;
      tick(3);
    end
    // all three at once come out in priority order
    traceEn <= 1'b1;
    irqOn <= 1'b1;
    tick(3);
    expQ.push_back({4'h2, 7'h05});
    expQ.push_back({4'h4, irqVec});
    expQ.push_back({4'h8, 7'h0B});
    // trap, trace and interrupt land on one edge so only the order decides
    trapExec <= 1'b1;
    trapNum <= 2'h3;
    done <= 1'b1;
    tick(1);
    trapExec <= 1'b0;
    done <= 1'b0;
    drain();
    close_out();
  end
endmodule // testbench
`default_nettype wire
